// ### hdl/tct_pkg.sv
// Shared constants for the three-channel interval timer
package tct_pkg;
  // ----------------------------------------------------------------
  // Byte addresses of the timer
  // ----------------------------------------------------------------
  localparam logic [19:0] TCT_ADDR_CNT0 = 20'h5F000; // Channel 0 counter
  localparam logic [19:0] TCT_ADDR_CNT1 = 20'h5F002; // Channel 1 counter
  localparam logic [19:0] TCT_ADDR_CNT2 = 20'h5F004; // Channel 2 counter
  localparam logic [19:0] TCT_ADDR_MODE = 20'h5F006; // Mode byte, write only
  // ----------------------------------------------------------------
  // Mode byte fields
  // ----------------------------------------------------------------
  localparam int TCT_MODE_SEL_LSB = 6; // Channel select, bits 7:6
  localparam int TCT_MODE_RPT_BIT = 2; // Repeating timer flag
  localparam int TCT_MODE_BCD_BIT = 0; // BCD counting
  localparam logic [5:0] TCT_MODE_LATCH = 6'h00; // Low bits of a latch command
  localparam logic [7:0] TCT_MODE_RESET = 8'h00; // Mode reset value
  // ----------------------------------------------------------------
  // Controller register offsets (word index on the user port)
  // ----------------------------------------------------------------
  localparam logic [3:0] TCT_REG_CTRL = 4'h0; // Write: go; bits 1:0 command
  localparam logic [3:0] TCT_REG_ADDR = 4'h1; // Bus byte address
  localparam logic [3:0] TCT_REG_DATA = 4'h2; // Write data / read result
  localparam logic [3:0] TCT_REG_STAT = 4'h3; // Bit 0 busy
  localparam logic [3:0] TCT_REG_IRQ_STAT = 4'h4; // Sticky events
  localparam logic [3:0] TCT_REG_IRQ_CLR = 4'h5; // Write one to clear
  localparam logic [3:0] TCT_REG_IRQ_EN = 4'h6; // Event enables
  localparam logic [1:0] TCT_CMD_WRITE = 2'h0; // Single byte write
  localparam logic [1:0] TCT_CMD_READ = 2'h1; // Single byte read
  localparam logic [1:0] TCT_CMD_LOAD = 2'h2; // Mode, low, high sequence
  localparam logic [1:0] TCT_CMD_RESET = 2'h3; // Two dummy reads per counter
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int TCT_CLK_KHZ = 200000; // System clock, 200 MHz
  localparam int TCT_CNT_KHZ = 2048; // Count clock, 2.048 MHz
  localparam int TCT_CNT_DIV = TCT_CLK_KHZ / TCT_CNT_KHZ; // Cycles per count tick
  localparam logic [15:0] TCT_CNT_RESET = 16'h0000; // Counter reset value
endpackage

// ### hdl/tct_if.sv
// Byte bus between host controller and timer device
`timescale 1ns/1ps
`default_nettype none
interface tct_if;
  logic [19:0] addr; // Byte address
  logic [7:0] wdata; // Write byte
  logic wr; // One-cycle write strobe
  logic rd; // One-cycle read strobe
  logic [7:0] rdata; // Read byte, cycle after rd
  logic ch0_out; // Baud-rate clock
  logic ch1_irq; // Channel 1 interrupt pulse
  logic ch2_irq; // Channel 2 interrupt pulse
  modport dev (input addr, wdata, wr, rd, output rdata, ch0_out, ch1_irq, ch2_irq);
  modport host (output addr, wdata, wr, rd, input rdata, ch0_out, ch1_irq, ch2_irq);
endinterface
`default_nettype wire

// ### hdl/tct_timer.sv
// Three-channel 16-bit down-counting timer, device end
`timescale 1ns/1ps
`default_nettype none
module tct_timer #(
  parameter int DIV = tct_pkg::TCT_CNT_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  tct_if.dev bus
);
  // ----------------------------------------------------------------
  // Count clock prescaler
  // ----------------------------------------------------------------
  logic [7:0] pre; // Prescale counter
  logic tick; // One count clock period elapsed

  // Divide the system clock down to the shared count rate
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre <= 8'h00;
    end else if (tick) begin
      pre <= 8'h00;
    end else begin
      pre <= pre + 8'h01;
    end
  end
  assign tick = (pre == 8'(DIV - 1));

  // Decrement one step, decimal per nibble in BCD mode
  function automatic logic [15:0] tct_dec(input logic [15:0] v, input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    if (!bcd) begin
      r = v - 16'h0001;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (borrow) begin
          if (v[i*4 +: 4] == 4'h0) begin
            r[i*4 +: 4] = 4'h9;
          end else begin
            r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Decode of the byte bus
  // ----------------------------------------------------------------
  logic mode_wr; // Mode byte write
  logic [2:0] cnt_sel; // Counter address hit per channel
  logic [1:0] mode_ch; // Channel named by mode byte
  assign mode_wr = bus.wr && (bus.addr == tct_pkg::TCT_ADDR_MODE);
  assign mode_ch = bus.wdata[tct_pkg::TCT_MODE_SEL_LSB +: 2];
  assign cnt_sel[0] = (bus.addr == tct_pkg::TCT_ADDR_CNT0);
  assign cnt_sel[1] = (bus.addr == tct_pkg::TCT_ADDR_CNT1);
  assign cnt_sel[2] = (bus.addr == tct_pkg::TCT_ADDR_CNT2);

  logic [15:0] cnt [3]; // Live counts
  logic [15:0] hold [3]; // Latched counts
  logic [2:0] hit_zero; // Terminal count this tick

  // ----------------------------------------------------------------
  // Per-channel counters
  // ----------------------------------------------------------------
  for (genvar c = 0; c < 3; c++) begin : g_ch
    logic [15:0] reload; // Programmed count
    logic bcd; // Decimal counting
    logic rpt; // Repeating timer mode
    logic wr_hi; // Next count write is high byte
    logic rd_hi; // Next read returns high byte
    logic latched; // Holding register armed
    logic run; // Full count loaded
    logic sel_mode; // Mode byte for this channel
    assign sel_mode = mode_wr && (mode_ch == 2'(c));
    assign hit_zero[c] = tick && run && (cnt[c] == 16'h0001);

    // Mode byte: format bits, or a latch command
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        bcd <= 1'b0;
        rpt <= 1'b0;
      end else if (sel_mode && bus.wdata[5:0] != tct_pkg::TCT_MODE_LATCH) begin
        bcd <= bus.wdata[tct_pkg::TCT_MODE_BCD_BIT];
        rpt <= bus.wdata[tct_pkg::TCT_MODE_RPT_BIT];
      end
    end

    // Count byte pairing: low then high, reset by a mode write other than a latch command
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        wr_hi <= 1'b0;
        reload <= tct_pkg::TCT_CNT_RESET;
        run <= 1'b0;
      end else if (sel_mode && bus.wdata[5:0] != tct_pkg::TCT_MODE_LATCH) begin
        wr_hi <= 1'b0; // Reprogramming stops the channel until both bytes land
        run <= 1'b0;
      end else if (bus.wr && cnt_sel[c]) begin
        if (!wr_hi) begin
          reload[7:0] <= bus.wdata;
          wr_hi <= 1'b1;
        end else begin
          reload[15:8] <= bus.wdata;
          wr_hi <= 1'b0;
          run <= 1'b1;
        end
      end
    end

    // Live counter: load on high byte, step each tick, reload at terminal
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt[c] <= tct_pkg::TCT_CNT_RESET;
      end else if (bus.wr && cnt_sel[c] && wr_hi) begin
        cnt[c] <= {bus.wdata, reload[7:0]};
      end else if (hit_zero[c] || (tick && run && cnt[c] == 16'h0000)) begin
        cnt[c] <= reload;
      end else if (tick && run) begin
        cnt[c] <= tct_dec(cnt[c], bcd);
      end
    end

    // Latch command and two-byte read sequencing
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        hold[c] <= tct_pkg::TCT_CNT_RESET;
        latched <= 1'b0;
        rd_hi <= 1'b0;
      end else if (sel_mode && bus.wdata[5:0] == tct_pkg::TCT_MODE_LATCH) begin
        hold[c] <= cnt[c];
        latched <= 1'b1;
        rd_hi <= 1'b0;
      end else if (bus.rd && cnt_sel[c]) begin
        rd_hi <= !rd_hi;
        if (rd_hi) begin
          latched <= 1'b0;
        end
      end else if (bus.rd && (cnt_sel != 3'b000)) begin
        // A read of another counter abandons a half-read pair, so the
        // dummy-read round leaves every channel at its low byte
        rd_hi <= 1'b0;
      end
    end

    // Byte presented for a read: latched value if armed, else live
    logic [15:0] rsrc;
    assign rsrc = latched ? hold[c] : cnt[c];
    logic [7:0] rbyte;
    assign rbyte = rd_hi ? rsrc[15:8] : rsrc[7:0];
  end

  // ----------------------------------------------------------------
  // Read data and outputs
  // ----------------------------------------------------------------
  // Read data stands in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata <= 8'h00;
    end else if (bus.rd) begin
      if (cnt_sel[0]) begin
        bus.rdata <= g_ch[0].rbyte;
      end else if (cnt_sel[1]) begin
        bus.rdata <= g_ch[1].rbyte;
      end else if (cnt_sel[2]) begin
        bus.rdata <= g_ch[2].rbyte;
      end else begin
        bus.rdata <= 8'h00; // Unmapped, including the mode address
      end
    end
  end

  // Baud clock toggles and interrupts pulse at terminal count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.ch0_out <= 1'b0;
      bus.ch1_irq <= 1'b0;
      bus.ch2_irq <= 1'b0;
    end else begin
      if (hit_zero[0]) begin
        bus.ch0_out <= !bus.ch0_out;
      end
      bus.ch1_irq <= hit_zero[1] && (g_ch[1].rpt || g_ch[1].run);
      bus.ch2_irq <= hit_zero[2] && (g_ch[2].rpt || g_ch[2].run);
    end
  end
endmodule
`default_nettype wire

// ### hdl/tct_host.sv
// Host-side controller driving the timer byte bus from a register port
`timescale 1ns/1ps
`default_nettype none
module tct_host (
  input wire logic clk,
  input wire logic rst_n,
  tct_if.host bus,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq
);
  // ----------------------------------------------------------------
  // Registers and sequencer
  // ----------------------------------------------------------------
  typedef enum {TCT_IDLE, TCT_RUN, TCT_WAIT, TCT_DATA} tct_state_t;
  tct_state_t state; // Sequencer state
  logic [19:0] tgt; // Target byte address
  logic [23:0] data; // Bytes: mode, low, high; or read result
  logic [1:0] cmd; // Active command
  logic [2:0] step; // Step within a command
  logic [2:0] ev_stat; // Done, ch1 irq, ch2 irq
  logic [2:0] ev_en; // Event enables
  logic done_ev; // Command finished
  logic [1:0] last; // Last step index of a write, read or load command

  assign last = (cmd == tct_pkg::TCT_CMD_LOAD) ? 2'd2 :
                (cmd == tct_pkg::TCT_CMD_RESET) ? 2'd1 : 2'd0;

  // Sequencer: one bus strobe per step, none for a read of the mode address; reads wait a cycle for data
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TCT_IDLE;
      step <= 3'd0;
      cmd <= tct_pkg::TCT_CMD_WRITE;
      tgt <= 20'h00000;
      data <= 24'h000000;
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      bus.addr <= 20'h00000;
      bus.wdata <= 8'h00;
      done_ev <= 1'b0;
    end else begin
      bus.wr <= 1'b0;
      bus.rd <= 1'b0;
      done_ev <= 1'b0;
      case (state)
        TCT_IDLE: begin
          if (reg_wr && reg_addr == tct_pkg::TCT_REG_CTRL) begin
            cmd <= reg_wdata[1:0];
            step <= 3'd0;
            state <= TCT_RUN;
          end else if (reg_wr && reg_addr == tct_pkg::TCT_REG_ADDR) begin
            tgt <= reg_wdata[19:0];
          end else if (reg_wr && reg_addr == tct_pkg::TCT_REG_DATA) begin
            data <= reg_wdata[23:0];
          end
        end
        TCT_RUN: begin
          case (cmd)
            tct_pkg::TCT_CMD_LOAD: begin
              bus.wr <= 1'b1;
              bus.addr <= (step == 3'd0) ? tct_pkg::TCT_ADDR_MODE : tgt;
              bus.wdata <= data[step[1:0]*8 +: 8];
            end
            tct_pkg::TCT_CMD_RESET: begin
              bus.rd <= 1'b1;
              bus.addr <= tct_pkg::TCT_ADDR_CNT0 + 20'({step[2:1], 1'b0});
            end
            tct_pkg::TCT_CMD_READ: begin
              bus.rd <= (tgt != tct_pkg::TCT_ADDR_MODE);
              bus.addr <= tgt;
            end
            default: begin
              bus.wr <= 1'b1;
              bus.addr <= tgt;
              bus.wdata <= data[7:0];
            end
          endcase
          state <= TCT_WAIT;
        end
        TCT_WAIT: begin
          if (cmd == tct_pkg::TCT_CMD_READ) begin
            state <= TCT_DATA; // Read byte only stands in the next cycle
          end else if ((cmd == tct_pkg::TCT_CMD_RESET && step == 3'd5) ||
              (cmd != tct_pkg::TCT_CMD_RESET && step[1:0] == last)) begin
            done_ev <= 1'b1;
            state <= TCT_IDLE;
          end else begin
            step <= step + 3'd1;
            state <= TCT_RUN;
          end
        end
        // Take the read byte while the device still presents it
        TCT_DATA: begin
          data <= {16'h0000, bus.rdata};
          done_ev <= 1'b1;
          state <= TCT_IDLE;
        end
        default: state <= TCT_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status: set wins over clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_stat <= 3'b000;
      ev_en <= 3'b000;
    end else begin
      ev_stat <= (ev_stat & ~((reg_wr && reg_addr == tct_pkg::TCT_REG_IRQ_CLR) ?
                 reg_wdata[2:0] : 3'b000)) | {bus.ch2_irq, bus.ch1_irq, done_ev};
      if (reg_wr && reg_addr == tct_pkg::TCT_REG_IRQ_EN) begin
        ev_en <= reg_wdata[2:0];
      end
    end
  end
  assign irq = |(ev_stat & ev_en);

  // Register read, data in the following cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        tct_pkg::TCT_REG_ADDR: reg_rdata <= {12'h000, tgt};
        tct_pkg::TCT_REG_DATA: reg_rdata <= {8'h00, data};
        tct_pkg::TCT_REG_STAT: reg_rdata <= {31'h00000000, state != TCT_IDLE};
        tct_pkg::TCT_REG_IRQ_STAT: reg_rdata <= {29'h00000000, ev_stat};
        tct_pkg::TCT_REG_IRQ_EN: reg_rdata <= {29'h00000000, ev_en};
        default: reg_rdata <= 32'h00000000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### testbench/tct_chk.sv
// Concurrent checks on the timer byte bus
`timescale 1ns/1ps
`default_nettype none
module tct_chk #(
  parameter int DIV = tct_pkg::TCT_CNT_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [19:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic ch0_out,
  input wire logic ch1_irq,
  input wire logic ch2_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Cycles since each channel's last event; no two fit inside a tick
  // ----------------------------------------------------------------
  logic [7:0] gap0; // Since last baud toggle
  logic [7:0] gap1; // Since last channel 1 pulse
  logic [7:0] gap2; // Since last channel 2 pulse
  logic prev0; // Baud level one cycle ago
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap0 <= 8'hFF;
      gap1 <= 8'hFF;
      gap2 <= 8'hFF;
      prev0 <= 1'b0;
    end else begin
      gap0 <= (ch0_out != prev0) ? 8'h00 : gap0 + {7'h00, gap0 != 8'hFF};
      gap1 <= ch1_irq ? 8'h00 : gap1 + {7'h00, gap1 != 8'hFF};
      gap2 <= ch2_irq ? 8'h00 : gap2 + {7'h00, gap2 != 8'hFF};
      prev0 <= ch0_out;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  strobe_excl_a: assert property (!(wr && rd))
    else $error("write and read strobes together");
  strobe_gap_a: assert property ((wr || rd) |=> !(wr || rd))
    else $error("bus strobes closer than two cycles");
  mode_noread_a: assert property (rd |-> addr != tct_pkg::TCT_ADDR_MODE)
    else $error("read of the mode address");
  rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
    else $error("read byte changed without a read");
  unmapped_zero_a: assert property (rd && addr[19:3] != 17'h0BE00 |=> rdata == 8'h00)
    else $error("unmapped read gave nonzero data");
  baud_gap_a: assert property ((ch0_out != prev0) |-> int'(gap0) >= DIV - 1)
    else $error("baud toggles closer than one count tick");
  ch1_gap_a: assert property (ch1_irq |-> int'(gap1) >= DIV - 1)
    else $error("channel 1 pulses closer than one count tick");
  ch2_gap_a: assert property (ch2_irq |-> int'(gap2) >= DIV - 1)
    else $error("channel 2 pulses closer than one count tick");
  // Main scenarios reached
  cover property (ch1_irq);
  cover property (ch0_out != prev0);
  cover property (wr && addr == tct_pkg::TCT_ADDR_MODE && wdata[5:0] == 6'h00);
endmodule
`default_nettype wire

// ### testbench/three_channel_interval_timer_tb.sv
// Self-checking bench for the timer device and its host controller
`timescale 1ns/1ps
`default_nettype none
module three_channel_interval_timer_tb;
  localparam int DIV = 4; // Short count tick keeps the run brief
  logic clk;
  logic rst_n;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic irq;
  logic ch0_q; // Baud level one cycle ago
  int n_mismatch;
  int num_checks;
  int ev[3]; // Events seen per channel
  tct_if bus ();
  tct_timer #(.DIV(DIV)) tct_timer_i (.clk(clk), .rst_n(rst_n), .bus(bus.dev));
  tct_host tct_host_i (.clk(clk), .rst_n(rst_n), .bus(bus.host), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  tct_chk #(.DIV(DIV)) tct_chk_i (.clk(clk), .rst_n(rst_n), .addr(bus.addr),
    .wdata(bus.wdata), .wr(bus.wr), .rd(bus.rd), .rdata(bus.rdata), .ch0_out(bus.ch0_out),
    .ch1_irq(bus.ch1_irq), .ch2_irq(bus.ch2_irq));
  // ----------------------------------------------------------------
  // Clock, event counters, shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ch0_q <= bus.ch0_out;
    if (bus.ch0_out !== ch0_q) ev[0] <= ev[0] + 1;
    if (bus.ch1_irq === 1'b1) ev[1] <= ev[1] + 1;
    if (bus.ch2_irq === 1'b1) ev[2] <= ev[2] + 1;
  end
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (exp !== got) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // Read data stand from the cycle after the strobe and hold until the next read
  task automatic rreg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask
  // Control, address and data writes are refused while busy, so every command waits for idle
  task automatic cmd(logic [1:0] c, logic [19:0] a, logic [31:0] d);
    logic [31:0] s;
    int n;
    wreg(tct_pkg::TCT_REG_ADDR, {12'h000, a});
    wreg(tct_pkg::TCT_REG_DATA, d);
    wreg(tct_pkg::TCT_REG_CTRL, {30'h0, c});
    n = 0;
    s = 32'h1;
    while (s[0] !== 1'b0 && n < 100) begin
      rreg(tct_pkg::TCT_REG_STAT, s);
      n++;
    end
    chk("busy", 32'h0, {31'h0, s[0]});
  endtask
  task automatic load(logic [7:0] m, logic [15:0] n);
    cmd(tct_pkg::TCT_CMD_LOAD, tct_pkg::TCT_ADDR_CNT0 + 20'({m[7:6], 1'b0}), {8'h00, n, m});
  endtask
  task automatic rd8(logic [1:0] c, output logic [7:0] b);
    logic [31:0] d;
    cmd(tct_pkg::TCT_CMD_READ, tct_pkg::TCT_ADDR_CNT0 + 20'({c, 1'b0}), 32'h0);
    rreg(tct_pkg::TCT_REG_DATA, d);
    b = d[7:0];
  endtask
  task automatic latch(logic [1:0] c, output logic [15:0] v);
    cmd(tct_pkg::TCT_CMD_WRITE, tct_pkg::TCT_ADDR_MODE, {24'h0, c, 6'h00});
    rd8(c, v[7:0]);
    rd8(c, v[15:8]);
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_irq();
    logic [31:0] d;
    rreg(tct_pkg::TCT_REG_IRQ_STAT, d);
    chk("stat after reset", 32'h0, d);
    wreg(tct_pkg::TCT_REG_IRQ_EN, 32'h1);
    cmd(tct_pkg::TCT_CMD_READ, 20'h5F008, 32'h0);
    rreg(tct_pkg::TCT_REG_DATA, d);
    chk("unmapped byte", 32'h0, {24'h0, d[7:0]});
    chk("irq raised", 32'h1, {31'h0, irq});
    wreg(tct_pkg::TCT_REG_IRQ_CLR, 32'h1);
    @(negedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wreg(tct_pkg::TCT_REG_IRQ_EN, 32'h0);
    cmd(tct_pkg::TCT_CMD_RESET, 20'h00000, 32'h0);
    chk("irq masked", 32'h0, {31'h0, irq});
    rreg(tct_pkg::TCT_REG_IRQ_STAT, d);
    chk("stat sticky", 32'h1, {31'h0, d[0]});
    $display("test_irq done");
  endtask
  // Count 3 gives one event every 3 ticks in every mode
  task automatic test_modes();
    logic [7:0] m [10];
    logic [1:0] c;
    m = '{8'h36, 8'h37, 8'h70, 8'h71, 8'hB0, 8'hB1, 8'h74, 8'h75, 8'hB4, 8'hB5};
    for (int i = 0; i < 10; i++) begin
      c = m[i][7:6];
      load(m[i], 16'h0003);
      ev[c] = 0;
      repeat (36 * DIV) @(posedge clk);
      chk("event count", 32'h1, {31'h0, ev[c] >= 11 && ev[c] <= 13});
    end
    $display("test_modes done");
  endtask
  task automatic test_latch();
    logic [15:0] v1;
    logic [15:0] v2;
    load(8'h70, 16'h1234);
    latch(2'h1, v1);
    chk("latched range", 32'h1, {31'h0, v1 <= 16'h1234 && v1 > 16'h1134});
    repeat (40 * DIV) @(posedge clk);
    latch(2'h1, v2);
    chk("count kept", 32'h1, {31'h0, v1 - v2 >= 16'h0028 && v1 - v2 < 16'h00C8});
    $display("test_latch done");
  endtask
  task automatic test_bcd();
    logic [15:0] v;
    logic [31:0] d;
    load(8'hB1, 16'h0100);
    repeat (20 * DIV) @(posedge clk);
    latch(2'h2, v);
    chk("decimal digits", 32'h1, {31'h0, v[7:4] <= 4'h9 && v[3:0] <= 4'h9});
    chk("decimal range", 32'h1, {31'h0, v < 16'h0100 && v > 16'h0050});
    // A decimal 100 period fires within 110 ticks and stays recorded
    wreg(tct_pkg::TCT_REG_IRQ_CLR, 32'h4);
    repeat (110 * DIV) @(posedge clk);
    rreg(tct_pkg::TCT_REG_IRQ_STAT, d);
    chk("ch2 event sticky", 32'h1, {31'h0, d[2]});
    $display("test_bcd done");
  endtask
  // A half-read latch leaves sequencing at high; the dummy reads undo it
  task automatic test_reset();
    logic [7:0] b;
    load(8'h36, 16'h8000);
    cmd(tct_pkg::TCT_CMD_WRITE, tct_pkg::TCT_ADDR_MODE, 32'h0);
    rd8(2'h0, b);
    cmd(tct_pkg::TCT_CMD_RESET, 20'h00000, 32'h0);
    rd8(2'h0, b);
    rd8(2'h0, b);
    chk("high byte order", 32'h7F, {24'h0, b});
    $display("test_reset done");
  endtask
  // Divisor 000D is the 9600 baud x16 entry: the level flips every 13 ticks
  task automatic test_baud();
    logic l;
    int n;
    load(8'h36, 16'h000D);
    @(negedge clk);
    for (int k = 0; k < 2; k++) begin
      l = bus.ch0_out;
      n = 0;
      while (bus.ch0_out === l && n < 1000) begin
        @(negedge clk);
        n++;
      end
    end
    chk("baud half period", 32'(13 * DIV), 32'(n));
    $display("test_baud done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Watchdog well past the expected run length
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    test_irq();
    test_modes();
    test_latch();
    test_bcd();
    test_reset();
    test_baud();
    end_sim();
  end
endmodule
`default_nettype wire
